// ### verilog/msb_pkg.sv
// shared constants of the module sideband two-wire target
// assumes a 40 MHz core clock and a host-driven serial clock
package msb_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SAMPLE_US     = 100;
  localparam int SAMPLE_CYC    = (SAMPLE_US * 1000) / CLK_PERIOD_NS;

  // ==========================================================
  // target address groups (upper four of seven address bits)
  localparam logic [3:0] GRP_SENSOR = 4'h3;
  localparam logic [3:0] GRP_CMD    = 4'h6;
  localparam logic [3:0] GRP_STORE  = 4'hA;

  // ==========================================================
  // store layout
  localparam int         STORE_BYTES = 512;
  localparam int         BLK_BYTES   = 128;
  localparam logic [8:0] RSV_FIRST   = 9'h100;
  localparam logic [8:0] RSV_LAST    = 9'h13F;
  localparam logic [7:0] RSV_FILL    = 8'h00;
  localparam logic [3:0] WP_RESET    = 4'h7;

  // broadcast commands, low three address bits (0..3 protect a block)
  localparam logic [2:0] CMD_CLR_WP = 3'h4;
  localparam logic [2:0] CMD_PAGE0  = 3'h6;
  localparam logic [2:0] CMD_PAGE1  = 3'h7;

  // ==========================================================
  // sensor pointers and fields
  localparam logic [2:0] PTR_CAPS = 3'h0;
  localparam logic [2:0] PTR_CFG  = 3'h1;
  localparam logic [2:0] PTR_HIGH = 3'h2;
  localparam logic [2:0] PTR_LOW  = 3'h3;
  localparam logic [2:0] PTR_CRIT = 3'h4;
  localparam logic [2:0] PTR_TEMP = 3'h5;
  localparam logic [2:0] PTR_STAT = 3'h6;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_EVT_EN   = 2;
  localparam int CFG_BRS_EN   = 3;
  localparam int CFG_HYST_LSB = 9;
  localparam int STAT_EVT     = 0;
  localparam int STAT_CLR     = 1;
  localparam int CAPS_ALARM   = 0;
  localparam int CAPS_RES_LSB = 3;
  localparam int TF_CRIT      = 15;
  localparam int TF_HIGH      = 14;
  localparam int TF_LOW       = 13;
  localparam logic [12:0] HIGH_RESET = 13'h0500;
  localparam logic [12:0] LOW_RESET  = 13'h0000;
  localparam logic [12:0] CRIT_RESET = 13'h05F0;
  localparam logic [15:0] CFG_RESET  = 16'h0000;
  localparam logic [12:0] HYST_1     = 13'h0018;
  localparam logic [12:0] HYST_2     = 13'h0030;
  localparam logic [12:0] HYST_3     = 13'h0060;

  typedef enum logic [1:0] {
    EVM_INT  = 2'h0,
    EVM_CMP  = 2'h1,
    EVM_CRIT = 2'h2
  } msb_evm_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_WR   = 5'h04,
    ST_RD   = 5'h08,
    ST_WAIT = 5'h10
  } msb_st_type;
endpackage : msb_pkg

// ### verilog/msb_sen_if.sv
// carrier between the bus engine and the thermal sensor
// assumes both ends run on core_clk
`timescale 1ns/1ps
`default_nettype none
interface msb_sen_if;
  logic [2:0]  ptr;
  logic        wr_en;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport ctl (output ptr, output wr_en, output wdata, input rdata);
  modport sen (input ptr, input wr_en, input wdata, output rdata);
endinterface : msb_sen_if
`default_nettype wire

// ### verilog/msb_bit_cap.sv
// serial-clock domain: captures each data bit on the clock rise
// assumes the host holds sda stable around every rising edge
`timescale 1ns/1ps
`default_nettype none
module msb_bit_cap (
  input  wire logic scl_clk,
  input  wire logic nrst,
  input  wire logic sda_i,
  output logic      bit_ff,
  output logic      tog_ff
);
  // ==========================================================
  // capture; toggle marks the event, bit stays stable a full period
  always_ff @(posedge scl_clk or negedge nrst) begin
    if (!nrst) begin
      bit_ff <= 1'b0;
      tog_ff <= 1'b0;
    end else begin
      bit_ff <= sda_i;
      tog_ff <= ~tog_ff;
    end
  end
endmodule : msb_bit_cap
`default_nettype wire

// ### verilog/msb_thermal.sv
// thermal sensor registers, alarm evaluation and event pin drive
// assumes temp_code comes from logic on core_clk, 1/16 degree units
`timescale 1ns/1ps
`default_nettype none
module msb_thermal #(
  parameter logic [1:0] RES_CODE = 2'h3
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [12:0] temp_code,
  input  wire logic        backup_ready_status,
  msb_sen_if.sen           sif,
  output logic             event_n_o,
  output logic             event_n_oe
);
  logic [12:0] temp_ff, high_ff, low_ff, crit_ff, hyst, rel_lvl;
  logic [15:0] cfg_ff;
  logic [11:0] smp_ff;
  logic        brs_s1_ff, brs_s2_ff, crit_st_ff, int_ff, alm_prev_ff, evt_ff;
  logic        alm, over_crit, under_rel, clr_wr, evt;
  msb_pkg::msb_evm_type mode;

  // drop bits finer than the fixed resolution
  function automatic logic [12:0] res_mask(input logic [12:0] t);
    unique case (RES_CODE)
      2'h0:    res_mask = {t[12:3], 3'h0};
      2'h1:    res_mask = {t[12:2], 2'h0};
      2'h2:    res_mask = {t[12:1], 1'h0};
      default: res_mask = t;
    endcase
  endfunction : res_mask

  // ==========================================================
  // periodic sampling keeps the reading current
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      smp_ff  <= 12'h000;
      temp_ff <= 13'h0000;
    end else if (smp_ff == 12'(msb_pkg::SAMPLE_CYC - 1)) begin
      smp_ff  <= 12'h000;
      temp_ff <= res_mask(temp_code);
    end else begin
      smp_ff <= smp_ff + 12'h001;
    end
  end

  // ==========================================================
  // host-writable registers; clear-event is a strobe, not stored
  assign clr_wr = sif.wr_en && sif.ptr == msb_pkg::PTR_STAT
                  && sif.wdata[msb_pkg::STAT_CLR];
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_ff  <= msb_pkg::CFG_RESET;
      high_ff <= msb_pkg::HIGH_RESET;
      low_ff  <= msb_pkg::LOW_RESET;
      crit_ff <= msb_pkg::CRIT_RESET;
    end else if (sif.wr_en) begin
      if (sif.ptr == msb_pkg::PTR_CFG) cfg_ff <= sif.wdata;
      if (sif.ptr == msb_pkg::PTR_HIGH) high_ff <= sif.wdata[12:0];
      if (sif.ptr == msb_pkg::PTR_LOW) low_ff <= sif.wdata[12:0];
      if (sif.ptr == msb_pkg::PTR_CRIT) crit_ff <= sif.wdata[12:0];
    end
  end

  // ==========================================================
  // alarm evaluation
  assign mode = msb_pkg::msb_evm_type'(cfg_ff[msb_pkg::CFG_MODE_LSB +: 2]);
  always_comb begin
    unique case (cfg_ff[msb_pkg::CFG_HYST_LSB +: 2])
      2'h1:    hyst = msb_pkg::HYST_1;
      2'h2:    hyst = msb_pkg::HYST_2;
      2'h3:    hyst = msb_pkg::HYST_3;
      default: hyst = 13'h0000;
    endcase
  end
  assign rel_lvl   = crit_ff - hyst;
  assign alm       = $signed(temp_ff) > $signed(high_ff)
                     || $signed(temp_ff) < $signed(low_ff);
  assign over_crit = $signed(temp_ff) > $signed(crit_ff);
  assign under_rel = $signed(temp_ff) < $signed(rel_lvl);

  // critical latch releases only below limit minus hysteresis
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) crit_st_ff <= 1'b0;
    else if (over_crit) crit_st_ff <= 1'b1;
    else if (under_rel) crit_st_ff <= 1'b0;
  end

  // interrupt latch: a new alarm edge wins over a same-cycle clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      int_ff      <= 1'b0;
      alm_prev_ff <= 1'b0;
    end else begin
      alm_prev_ff <= alm;
      int_ff <= (mode == msb_pkg::EVM_INT && alm && !alm_prev_ff)
                || (int_ff && !clr_wr);
    end
  end

  // backup-ready comes from another device; two flops before use
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      brs_s1_ff <= 1'b1;
      brs_s2_ff <= 1'b1;
    end else begin
      brs_s1_ff <= backup_ready_status;
      brs_s2_ff <= brs_s1_ff;
    end
  end

  // ==========================================================
  // event pin, open drain: pulled low by sensor alarms or by lost backup-ready
  always_comb begin
    unique case (mode)
      msb_pkg::EVM_INT:  evt = int_ff || crit_st_ff;
      msb_pkg::EVM_CMP:  evt = alm || crit_st_ff;
      msb_pkg::EVM_CRIT: evt = crit_st_ff;
      default:           evt = 1'b0;
    endcase
    evt = (evt && cfg_ff[msb_pkg::CFG_EVT_EN])
          || (cfg_ff[msb_pkg::CFG_BRS_EN] && !brs_s2_ff);
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) evt_ff <= 1'b0;
    else evt_ff <= evt;
  end
  assign event_n_o  = 1'b0;
  assign event_n_oe = evt_ff;

  // ==========================================================
  // read mux
  always_comb begin
    sif.rdata = 16'h0000;
    unique case (sif.ptr)
      msb_pkg::PTR_CAPS: begin
        sif.rdata[msb_pkg::CAPS_ALARM] = 1'b1;
        sif.rdata[msb_pkg::CAPS_RES_LSB +: 2] = RES_CODE;
      end
      msb_pkg::PTR_CFG:  sif.rdata = cfg_ff;
      msb_pkg::PTR_HIGH: sif.rdata[12:0] = high_ff;
      msb_pkg::PTR_LOW:  sif.rdata[12:0] = low_ff;
      msb_pkg::PTR_CRIT: sif.rdata[12:0] = crit_ff;
      msb_pkg::PTR_TEMP: begin
        sif.rdata[12:0] = temp_ff;
        sif.rdata[msb_pkg::TF_CRIT] = over_crit;
        sif.rdata[msb_pkg::TF_HIGH] = $signed(temp_ff) > $signed(high_ff);
        sif.rdata[msb_pkg::TF_LOW]  = $signed(temp_ff) < $signed(low_ff);
      end
      msb_pkg::PTR_STAT: sif.rdata[msb_pkg::STAT_EVT] = evt_ff;
      default:           sif.rdata = 16'h0000;
    endcase
  end
endmodule : msb_thermal
`default_nettype wire

// ### verilog/msb_sideband_target.sv
// two-wire sideband target: presence-detect store, thermal sensor
// and broadcast page / protect commands behind one serial port
// assumes an open-drain bus wired outside, host as only master,
// serial clock at most 1 MHz against the 40 MHz core clock
//
// Operation
// - sensor samples temperature once every 100 us sample period
// - fixed resolution, reported in capabilities register
// - event pin open-drain, driven by sensor alarms and backup-ready loss
// - backup-ready loss may also pull event
// - interrupt mode holds event until clear write
// - comparator mode releases event when alarm ends
// - critical limit always compared in comparator fashion
// - critical-only mode, release below limit minus hysteresis
// - 512-byte store, four protectable 128-byte blocks
// - bytes 0x100-0x13F reserved, read as zero
// - lower 384 bytes protected, top block open
// - target timed by 40 MHz core clock, host serial clock at most 1 MHz
// - store reachable only over the two-wire port
// - low address bits come from slot straps
// - store at 0x50-0x57, sensor at 0x18-0x1F
// - page and protect commands broadcast, straps ignored
// - backup controller and redriver addresses left alone
`timescale 1ns/1ps
`default_nettype none
module msb_sideband_target #(
  parameter logic [1:0] RES_CODE = 2'h3
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        scl_clk,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic [2:0]  slot_address_straps,
  input  wire logic [12:0] temp_code,
  input  wire logic        backup_ready_status,
  output logic             event_n_o,
  output logic             event_n_oe
);
  localparam int         SY_SCL    = 0;
  localparam int         SY_SDA    = 1;
  localparam int         SY_TOG    = 2;
  localparam logic [3:0] CNT_ACK   = 4'h8;
  localparam logic [3:0] CNT_AFTER = 4'h9;

  msb_sen_if sif ();

  logic [2:0]  sy1_ff;
  logic [2:0]  sy2_ff;
  logic [2:0]  sy3_ff;
  logic [2:0]  strap_s1_ff;
  logic [2:0]  strap_s2_ff;
  logic [2:0]  straps_ff;
  logic        strap_done_ff;
  logic [1:0]  strap_arm_ff;
  logic        cap_bit;
  logic        cap_tog;
  msb_pkg::msb_st_type st_ff;
  logic [3:0]  cnt_ff;
  logic [7:0]  shf_ff;
  logic [7:0]  tx_ff;
  logic [7:0]  ee_ptr_ff;
  logic [7:0]  hold_ff;
  logic [7:0]  rd_byte;
  logic        drv_ff;
  logic        rw_ff;
  logic        first_ff;
  logic        tgt_store_ff;
  logic        tgt_sen_ff;
  logic        page_ff;
  logic        sen_hi_ff;
  logic [3:0]  wp_ff;
  logic [2:0]  sen_ptr_ff;
  logic [7:0]  mem [0:msb_pkg::STORE_BYTES-1];
  logic [8:0]  ee_addr;
  logic        start_evt;
  logic        stop_evt;
  logic        fall_evt;
  logic        bit_evt;
  logic        hit_store;
  logic        hit_sen;
  logic        hit_cmd;
  logic        addr_ack;
  logic        addr_evt;
  logic        wr_evt;
  logic        load_evt;

  // inside the reserved window
  function automatic logic is_rsv(input logic [8:0] a);
    is_rsv = a >= msb_pkg::RSV_FIRST && a <= msb_pkg::RSV_LAST;
  endfunction : is_rsv

  // block not protected and not reserved
  function automatic logic can_write(input logic [8:0] a,
                                     input logic [3:0] wp);
    can_write = !wp[a[8:7]] && !is_rsv(a);
  endfunction : can_write

  // ==========================================================
  // serial-clock side: captures data bits; scl and sda also reach the synchronisers directly
  msb_bit_cap u_cap (
    .scl_clk (scl_clk),
    .nrst    (nrst),
    .sda_i   (sda_i),
    .bit_ff  (cap_bit),
    .tog_ff  (cap_tog)
  );

  // ==========================================================
  // synchronisers: first stage feeds only the second
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sy1_ff <= 3'h3;
      sy2_ff <= 3'h3;
      sy3_ff <= 3'h3;
    end else begin
      sy1_ff <= {cap_tog, sda_i, scl_clk};
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
    end
  end

  // frame edges seen from the synchronised pins
  assign start_evt = sy2_ff[SY_SCL] && sy3_ff[SY_SCL]
                     && sy3_ff[SY_SDA] && !sy2_ff[SY_SDA];
  assign stop_evt  = sy2_ff[SY_SCL] && sy3_ff[SY_SCL]
                     && !sy3_ff[SY_SDA] && sy2_ff[SY_SDA];
  assign fall_evt  = sy3_ff[SY_SCL] && !sy2_ff[SY_SCL];
  // cap_bit is read only after its toggle has crossed; it then
  // stays put for a whole serial period, far longer than the delay
  assign bit_evt   = sy2_ff[SY_TOG] ^ sy3_ff[SY_TOG];

  // ==========================================================
  // straps: synchronised, then held from the third edge on
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      strap_s1_ff   <= 3'h0;
      strap_s2_ff   <= 3'h0;
      straps_ff     <= 3'h0;
      strap_arm_ff  <= 2'h0;
      strap_done_ff <= 1'b0;
    end else begin
      strap_s1_ff <= slot_address_straps;
      strap_s2_ff <= strap_s1_ff;
      // wait out both stages, else the reset zeros get frozen
      if (!strap_done_ff) begin
        straps_ff     <= strap_s2_ff;
        strap_arm_ff  <= {strap_arm_ff[0], 1'b1};
        strap_done_ff <= strap_arm_ff[1];
      end
    end
  end

  // ==========================================================
  // address decode; 0x10-0x17 and 0x58-0x5F never match here,
  // so the backup controller and redriver answer for themselves
  assign hit_store = shf_ff[7:4] == msb_pkg::GRP_STORE
                     && shf_ff[3:1] == straps_ff;
  assign hit_sen   = shf_ff[7:4] == msb_pkg::GRP_SENSOR
                     && shf_ff[3:1] == straps_ff;
  assign hit_cmd   = shf_ff[7:4] == msb_pkg::GRP_CMD
                     && !shf_ff[0];
  assign addr_ack  = hit_store || hit_sen || hit_cmd;

  // byte-level events, all on a synchronised falling edge
  assign addr_evt = fall_evt && cnt_ff == CNT_ACK
                    && st_ff == msb_pkg::ST_ADDR && addr_ack;
  assign wr_evt   = fall_evt && cnt_ff == CNT_ACK
                    && st_ff == msb_pkg::ST_WR;
  assign load_evt = fall_evt && cnt_ff == CNT_AFTER
                    && (st_ff == msb_pkg::ST_RD
                        || (st_ff == msb_pkg::ST_ADDR && rw_ff));

  // ==========================================================
  // bit engine: bits count 0..7, ack slot at 8, its high half at 9
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff  <= msb_pkg::ST_IDLE;
      cnt_ff <= 4'h0;
      shf_ff <= 8'h00;
      drv_ff <= 1'b0;
      tx_ff  <= 8'h00;
    end else if (start_evt) begin
      st_ff  <= msb_pkg::ST_ADDR;
      cnt_ff <= 4'h0;
      drv_ff <= 1'b0;
    end else if (stop_evt) begin
      st_ff  <= msb_pkg::ST_IDLE;
      cnt_ff <= 4'h0;
      drv_ff <= 1'b0;
    end else if (bit_evt && st_ff != msb_pkg::ST_IDLE
                 && st_ff != msb_pkg::ST_WAIT) begin
      shf_ff <= {shf_ff[6:0], cap_bit};
      if (cnt_ff == CNT_ACK) begin
        cnt_ff <= CNT_AFTER;
        // host not-ack ends a read
        if (st_ff == msb_pkg::ST_RD && cap_bit) st_ff <= msb_pkg::ST_WAIT;
      end else begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end else if (fall_evt) begin
      if (cnt_ff == CNT_ACK) begin
        if (st_ff == msb_pkg::ST_ADDR) begin
          drv_ff <= addr_ack;
          if (!addr_ack) st_ff <= msb_pkg::ST_WAIT;
        end else begin
          drv_ff <= st_ff == msb_pkg::ST_WR;
        end
      end else if (cnt_ff == CNT_AFTER) begin
        cnt_ff <= 4'h0;
        if (load_evt) begin
          drv_ff <= !rd_byte[7];
          tx_ff  <= {rd_byte[6:0], 1'b0};
        end else begin
          drv_ff <= 1'b0;
        end
        if (st_ff == msb_pkg::ST_ADDR) begin
          st_ff <= rw_ff ? msb_pkg::ST_RD : msb_pkg::ST_WR;
        end
      end else if (st_ff == msb_pkg::ST_RD && cnt_ff != 4'h0) begin
        drv_ff <= !tx_ff[7];
        tx_ff  <= {tx_ff[6:0], 1'b0};
      end
    end
  end

  // open drain: enable pulls low, never drive high
  assign sda_o  = 1'b0;
  assign sda_oe = drv_ff;

  // ==========================================================
  // transfer context latched at the address ack
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rw_ff        <= 1'b0;
      tgt_store_ff <= 1'b0;
      tgt_sen_ff   <= 1'b0;
      first_ff     <= 1'b0;
    end else if (addr_evt) begin
      rw_ff        <= shf_ff[0];
      tgt_store_ff <= hit_store;
      tgt_sen_ff   <= hit_sen;
      first_ff     <= 1'b1;
    end else if (wr_evt) begin
      first_ff <= 1'b0;
    end
  end

  // ==========================================================
  // broadcast commands: page select and block protection;
  // straps are not compared so every module takes them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      page_ff <= 1'b0;
      wp_ff   <= msb_pkg::WP_RESET;
    end else if (addr_evt && hit_cmd) begin
      unique case (shf_ff[3:1])
        msb_pkg::CMD_PAGE0:  page_ff <= 1'b0;
        msb_pkg::CMD_PAGE1:  page_ff <= 1'b1;
        msb_pkg::CMD_CLR_WP: wp_ff <= 4'h0;
        3'h5:                wp_ff <= wp_ff;
        default:             wp_ff[shf_ff[2:1]] <= 1'b1;
      endcase
    end
  end

  // ==========================================================
  // store pointer: first written byte sets it, then it advances
  // within the 256-byte page
  assign ee_addr = {page_ff, ee_ptr_ff};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ee_ptr_ff <= 8'h00;
    end else if (wr_evt && tgt_store_ff) begin
      ee_ptr_ff <= first_ff ? shf_ff : ee_ptr_ff + 8'h01;
    end else if (load_evt && tgt_store_ff) begin
      ee_ptr_ff <= ee_ptr_ff + 8'h01;
    end
  end

  // store array; no reset, contents persist like the nonvolatile part
  always_ff @(posedge core_clk) begin
    if (wr_evt && tgt_store_ff && !first_ff
        && can_write(ee_addr, wp_ff)) begin
      mem[ee_addr] <= shf_ff;
    end
  end

  // ==========================================================
  // sensor access: pointer byte, then high and low byte pairs
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sen_ptr_ff <= msb_pkg::PTR_CAPS;
      sen_hi_ff  <= 1'b1;
      hold_ff    <= 8'h00;
    end else if (addr_evt) begin
      sen_hi_ff <= 1'b1;
    end else if (wr_evt && tgt_sen_ff) begin
      if (first_ff) begin
        sen_ptr_ff <= shf_ff[2:0];
        sen_hi_ff  <= 1'b1;
      end else if (sen_hi_ff) begin
        hold_ff   <= shf_ff;
        sen_hi_ff <= 1'b0;
      end else begin
        sen_hi_ff <= 1'b1;
      end
    end else if (load_evt && tgt_sen_ff) begin
      sen_hi_ff <= !sen_hi_ff;
    end
  end

  // a write lands only once both bytes arrived
  assign sif.ptr   = sen_ptr_ff;
  assign sif.wdata = {hold_ff, shf_ff};
  assign sif.wr_en = wr_evt && tgt_sen_ff && !first_ff && !sen_hi_ff;

  // ==========================================================
  // read byte select
  always_comb begin
    rd_byte = msb_pkg::RSV_FILL;
    if (tgt_sen_ff) begin
      rd_byte = sen_hi_ff ? sif.rdata[15:8] : sif.rdata[7:0];
    end else if (!is_rsv(ee_addr)) begin
      rd_byte = mem[ee_addr];
    end
  end

  // ==========================================================
  // thermal sensor and event pin
  msb_thermal #(
    .RES_CODE (RES_CODE)
  ) u_thermal (
    .core_clk            (core_clk),
    .nrst                (nrst),
    .temp_code           (temp_code),
    .backup_ready_status (backup_ready_status),
    .sif                 (sif),
    .event_n_o           (event_n_o),
    .event_n_oe          (event_n_oe)
  );
endmodule : msb_sideband_target
`default_nettype wire

// ### testbench/msb_sideband_target_properties.sv
// checker: serial and event pin behaviour of the sideband target
// assumes a bind to msb_sideband_target, all in the core_clk domain
`timescale 1ns/1ps
`default_nettype none
module msb_sideband_target_properties (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic scl_clk,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic event_n_o,
  input wire logic event_n_oe
);
  logic [8:0] drv_run_ff;
  // ========
  // drive length: ack plus eight zero bits is the longest legal pull
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) drv_run_ff <= 9'h000;
    else drv_run_ff <= sda_oe ? drv_run_ff + 9'h001 : 9'h000;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence scl_low_run;
    !scl_clk [*8];
  endsequence
  sda_drain_a: assert property (sda_o == 1'b0)
    else $error("sda data not low");
  evt_drain_a: assert property (event_n_o == 1'b0)
    else $error("event data not low");
  rst_quiet_a: assert property ($rose(nrst) |-> !sda_oe && !event_n_oe)
    else $error("pins driven out of reset");
  ack_rise_a: assert property ($rose(sda_oe) |-> !scl_clk)
    else $error("sda pulled while scl high");
  ack_fall_a: assert property ($fell(sda_oe) |-> !scl_clk)
    else $error("sda freed while scl high");
  high_hold_a: assert property (scl_clk && $past(scl_clk) |-> $stable(sda_oe))
    else $error("sda moved during scl high");
  early_turn_a: assert property ($changed(sda_oe) |-> ##1 scl_low_run)
    else $error("sda turned late in low phase");
  drv_bound_a: assert property (drv_run_ff < 9'h190)
    else $error("sda held too long");
endmodule : msb_sideband_target_properties
`default_nettype wire

// ### testbench/msb_host.sv
// host bus master model: drives the serial clock and a data pull-down
// assumes the bench resolves sda with a pull-up from all enables
`timescale 1ns/1ps
`default_nettype none
module msb_host (
  output var logic scl,
  output var logic oe,
  input  wire logic sda
);
  localparam int HALF_NS = 500;
  // ========
  // scl stands high between frames, sda left to its pull-up
  initial begin
    scl = 1'b1;
    oe  = 1'b0;
  end
  // data moves mid-low so it never races the clock fall
  task automatic bit_x(input logic b, output logic r);
    #(HALF_NS/2) oe <= !b;
    #(HALF_NS/2) scl <= 1'b1;
    #HALF_NS r = sda;
    scl <= 1'b0;
  endtask : bit_x
  task automatic start;
    #3 oe <= 1'b0;
    #(HALF_NS/2) scl <= 1'b1;
    #HALF_NS oe <= 1'b1;
    #HALF_NS scl <= 1'b0;
  endtask : start
  task automatic stop;
    #(HALF_NS/2) oe <= 1'b1;
    #(HALF_NS/2) scl <= 1'b1;
    #HALF_NS oe <= 1'b0;
    #HALF_NS;
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, nak);
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask : rbyte
endmodule : msb_host
`default_nettype wire

// ### testbench/tb_module_sideband_i2c_target.sv
// bench for the sideband target: store, broadcast and event checks
// assumes msb_host as the only master and a pull-up on the data wire
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_module_sideband_i2c_target;
  localparam logic [6:0] SEN = 7'h1D; // straps tied to 5
  localparam logic [6:0] STO = 7'h55;
  logic        core_clk, nrst, scl, h_oe, sda_o, sda_oe, ev_o, ev_oe, brs, nk;
  logic [12:0] temp;
  logic [15:0] rv;
  logic [6:0]  odd_adr [3] = '{7'h51, 7'h15, 7'h5D};
  int          err_total, n_checks;
  wire         sda = !(h_oe | sda_oe);
  msb_host host (.scl(scl), .oe(h_oe), .sda(sda));
  msb_sideband_target dut (.core_clk(core_clk), .nrst(nrst), .scl_clk(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .slot_address_straps(3'h5), .temp_code(temp),
    .backup_ready_status(brs), .event_n_o(ev_o), .event_n_oe(ev_oe));
  // ========
  // transfers: address, then n bytes taken from the top of d
  task automatic wr(input logic [6:0] a, input logic [23:0] d, input int n, output logic k);
    logic x;
    host.start();
    host.wbyte({a, 1'b0}, k);
    for (int i = 0; i < n; i++) host.wbyte(d[23-8*i -: 8], x);
    host.stop();
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n,
                    output logic [15:0] d);
    logic       x;
    logic [7:0] b;
    host.start();
    host.wbyte({a, 1'b0}, x);
    host.wbyte(p, x);
    host.start();
    host.wbyte({a, 1'b1}, x);
    d = 16'h0000;
    for (int i = 0; i < n; i++) begin
      host.rbyte(i == n - 1, b);
      d = {d[7:0], b};
    end
    host.stop();
  endtask : rd
  // one sample period of 4000 cycles plus margin before looking
  task automatic heat(input logic [12:0] t, input logic e, input string nm);
    @(posedge core_clk);
    temp <= t;
    repeat (4100) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(nm, e, ev_oe)
  endtask : heat
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // long hang guard, above the expected one and a half milliseconds of traffic
  initial begin
    #2400us;
    err_total++;
    end_of_test();
  end
  initial begin
    nrst = 1'b0;
    brs  = 1'b1;
    temp = 13'h0190;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd(SEN, 8'h00, 2, rv);
    `CHK("caps", 16'h0019, rv)
    heat(13'h0190, 1'b0, "idle");
    rd(SEN, 8'h05, 2, rv);
    `CHK("temp", 16'h0190, rv)
    wr(SEN, 24'h01_0005, 3, nk);
    heat(13'h0510, 1'b1, "cmp_set");
    heat(13'h0190, 1'b0, "cmp_free");
    wr(SEN, 24'h01_0004, 3, nk);
    heat(13'h0510, 1'b1, "int_set");
    heat(13'h0190, 1'b1, "int_hold");
    wr(SEN, 24'h06_0002, 3, nk);
    `CHK("int_clear", 1'b0, ev_oe)
    wr(SEN, 24'h01_0006, 3, nk);
    heat(13'h0510, 1'b0, "crit_only_high");
    heat(13'h0600, 1'b1, "crit_set");
    heat(13'h05EF, 1'b0, "crit_free");
    heat(13'h0190, 1'b0, "crit_low");
    wr(SEN, 24'h01_000C, 3, nk);
    `CHK("backup_idle", 1'b0, ev_oe)
    @(posedge core_clk);
    brs <= 1'b0;
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    `CHK("backup_evt", 1'b1, ev_oe)
    wr(7'h34, 24'h00_0000, 2, nk);
    `CHK("bcast_ack", 1'b0, nk)
    wr(STO, 24'h10_3C00, 2, nk);
    `CHK("store_ack", 1'b0, nk)
    wr(7'h30, 24'h00_0000, 2, nk);
    wr(STO, 24'h10_FF00, 2, nk);
    rd(STO, 8'h10, 1, rv);
    `CHK("wp_keep", 16'h003C, rv)
    wr(7'h37, 24'h00_0000, 2, nk);
    wr(STO, 24'h80_A500, 2, nk);
    rd(STO, 8'h80, 1, rv);
    `CHK("top_block", 16'h00A5, rv)
    rd(STO, 8'h00, 1, rv);
    `CHK("reserved", 16'h0000, rv)
    foreach (odd_adr[i]) begin
      wr(odd_adr[i], 24'h00_0000, 0, nk);
      `CHK("no_ack", 1'b1, nk)
    end
    end_of_test();
  end
endmodule : tb_module_sideband_i2c_target
bind msb_sideband_target msb_sideband_target_properties chk (.core_clk(core_clk),
  .nrst(nrst), .scl_clk(scl_clk), .sda_o(sda_o), .sda_oe(sda_oe),
  .event_n_o(event_n_o), .event_n_oe(event_n_oe));
`default_nettype wire
